// ### common/tic_pkg.sv
// Shared constants and types for the timer input-capture section.
// Assumes a 32-bit APB slave port with byte addresses, one clock domain.
package tic_pkg;

    // Register byte offsets on the APB port
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] OFF_FLAGS_CONTROL = 8'h04;
    localparam logic [7:0] OFF_SETUP = 8'h08;
    localparam logic [7:0] OFF_COUNTER = 8'h0C;
    // Capture registers: upper byte at base + 8*ch, lower byte 4 above it
    localparam logic [7:0] OFF_CAPTURE_BASE = 8'h10;
    localparam logic [7:0] OFF_CAPTURE_LAST = 8'h2C;
    localparam int CAPTURE_STRIDE_LOG2 = 3;
    localparam int CAPTURE_LOW_BIT = 2;

    // Reset and low-power initial values, plus the counter top value
    localparam logic [7:0] IRQ_ENABLE_RST = 8'h01;
    localparam logic [7:0] FLAGS_CONTROL_RST = 8'h00;
    localparam logic [7:0] SETUP_RST = 8'h00;
    localparam logic [15:0] CAPTURE_RST = 16'h0000;
    localparam logic [15:0] COUNTER_RST = 16'h0000;
    localparam logic [15:0] COUNTER_TOP = 16'hFFFF;
    localparam logic [7:0] HOLD_RST = 8'h00;

    // Field positions shared by the enable and flag registers
    localparam int BIT_CAPTURE_A = 7;
    localparam int BIT_CAPTURE_D = 4;
    localparam int BIT_COMPARE_A = 3;
    localparam int BIT_COMPARE_B = 2;
    localparam int BIT_OVERFLOW = 1;
    localparam int BIT_CLEAR_ON_MATCH = 0;
    localparam int BIT_RESERVED = 0;

    // Channel count and indices
    localparam int NUM_CHANNELS = 4;
    localparam int CH_A = 0;
    localparam int CH_B = 1;
    localparam int CH_C = 2;
    localparam int CH_D = 3;

    // Timer setup register layout, bit 7 down to bit 0
    typedef struct packed {
        logic edge_select_a;
        logic edge_select_b;
        logic edge_select_c;
        logic edge_select_d;
        logic buffer_on_a;
        logic buffer_on_b;
        logic [1:0] clock_select;
    } tic_setup_t;

    // Interrupt request lines towards the CPU
    typedef struct packed {
        logic capture_irq_a;
        logic capture_irq_b;
        logic capture_irq_c;
        logic capture_irq_d;
        logic compare_irq_a;
        logic compare_irq_b;
        logic overflow_irq;
    } tic_irq_t;

endpackage

// ### hw/tic_capture.sv
// Input-capture section of a 16-bit free-running timer with APB registers.
// Assumes capture pins are asynchronous, compare-match and count-tick
// pulses come from timer logic on clk, and APB runs on clk too.
//
// Functional notes
// - Selected edge copies counter, sets capture flag
// - Interrupt when flag set and enable one
// - C buffers A, D buffers B when enabled
// - Buffered edge pairs: fall, both, undefined, rise
// - Capture overwrites regardless of flag state
// - Capture registers zero on reset, low power
// - Enable bits: captures 7-4, compares, overflow
// - Enable bit 0 reads one, ignores writes
// - Enable register initialises to 0x01
// - Flag/control register initialises to 0x00
// - Flags bits 7-1, clear-on-match bit 0
// - Flags cleared by read-one-then-write-zero only
// - Buffered A: old A moves into C
// - Buffered B: old B moves into D
// - Buffered A: input C sets flag only
// - Capture values read through byte latch
// - Edge select zero falling, one rising
// - Clear-on-match clears counter on compare A
// - Buffered B: input D sets flag only
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps

module tic_capture
    import tic_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Capture pins, asynchronous, index 0 is channel A
    input wire logic [NUM_CHANNELS-1:0] capture_in,
    // Timer events on clk
    input wire logic count_tick,
    input wire logic compare_match_a,
    input wire logic compare_match_b,
    input wire logic low_power_init,
    // Timer state and requests
    output logic [15:0] free_running_counter,
    output logic [1:0] clock_select,
    output tic_irq_t irq
);

    // Edge qualifier for one unbuffered channel
    function automatic logic edge_hit(input logic rise, input logic fall,
                                      input logic sel);
        edge_hit = sel ? rise : fall;
    endfunction

    // Edge qualifier for a buffered pair; 1/0 selects nothing
    function automatic logic pair_hit(input logic rise, input logic fall,
                                      input logic sel_p, input logic sel_b);
        case ({sel_p, sel_b})
            2'b00: pair_hit = fall;
            2'b01: pair_hit = rise | fall;
            2'b11: pair_hit = rise;
            default: pair_hit = 1'b0;
        endcase
    endfunction

    // Register decode, used for reads and writes alike
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        logic [7:0] a8;
        a8 = a[7:0];
        addr_mapped = (a8[1:0] == 2'b00) &&
                      ((a8 <= OFF_COUNTER) ||
                       (a8 >= OFF_CAPTURE_BASE && a8 <= OFF_CAPTURE_LAST));
    endfunction

    // Synchroniser and edge history for the pins
    logic [NUM_CHANNELS-1:0] pin_meta; // First stage, read by pin_sync only
    logic [NUM_CHANNELS-1:0] pin_sync;
    logic [NUM_CHANNELS-1:0] pin_prev;
    logic [NUM_CHANNELS-1:0] rise;
    logic [NUM_CHANNELS-1:0] fall;
    logic [NUM_CHANNELS-1:0] hit; // Valid edge per channel this cycle
    // Software-visible state
    logic [15:0] cap_val [NUM_CHANNELS]; // Capture registers A..D
    logic [7:1] irq_enable; // Bit 0 is not stored
    logic [7:1] flags; // Hardware-set status flags
    logic [7:1] flag_seen; // Flag read as one since last set
    logic clear_on_match_a;
    tic_setup_t setup;
    logic [7:0] hold_low; // Byte holding latch
    logic [15:0] counter;
    // Derived control
    logic [NUM_CHANNELS-1:0] sel; // Edge selects, index 0 is A
    logic [1:0] buf_on; // Buffer enables, index 0 is A
    logic [7:1] set_ev; // Flag set events
    logic [7:1] clr_ev; // Flag clear requests
    logic overflow_ev;
    logic clear_now;
    logic [15:0] next_counter;
    // Bus phases
    logic setup_phase;
    logic access_done;
    logic wr_done;
    logic rd_done;
    logic [7:0] a8;
    logic [31:0] next_rdata;
    logic next_err;
    logic err_q;
    logic [1:0] rd_ch; // Capture channel of the address
    logic rd_upper; // Address is an upper-byte view

    assign a8 = paddr[7:0];
    assign sel = {setup.edge_select_d, setup.edge_select_c,
                  setup.edge_select_b, setup.edge_select_a};
    assign buf_on = {setup.buffer_on_b, setup.buffer_on_a};
    assign clock_select = setup.clock_select;
    assign free_running_counter = counter;

    // Zero-wait slave: every access phase completes in its first cycle
    assign pready = 1'b1;
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & pready;
    assign wr_done = access_done & pwrite & ~err_q;
    assign rd_done = access_done & ~pwrite & ~err_q;
    assign pslverr = psel & penable & err_q;

    // Two flip-flops per pin before any edge logic looks at it; the
    // source keeps each level long enough for the second stage to see it
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
            pin_prev <= '0;
        end
        else
        begin
            pin_meta <= capture_in;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    assign rise = pin_sync & ~pin_prev;
    assign fall = ~pin_sync & pin_prev;

    // Valid-edge selection; in buffered mode the spare channel keeps
    // its own edge select for flag setting but stops loading
    always_comb
    begin
        for (int k = 0; k < 2; k++)
        begin
            if (buf_on[k])
            begin
                hit[k] = pair_hit(rise[k], fall[k], sel[k], sel[k+2]);
            end
            else
            begin
                hit[k] = edge_hit(rise[k], fall[k], sel[k]);
            end
            hit[k+2] = edge_hit(rise[k+2], fall[k+2], sel[k+2]);
        end
    end

    // Capture registers, one pair (primary, buffer) per generate step
    for (genvar k = 0; k < 2; k++)
    begin : g_pair
        always_ff @(posedge clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                cap_val[k] <= CAPTURE_RST;
                cap_val[k+2] <= CAPTURE_RST;
            end
            else if (low_power_init)
            begin
                cap_val[k] <= CAPTURE_RST;
                cap_val[k+2] <= CAPTURE_RST;
            end
            else
            begin
                // Loaded whatever the flag says; the flag is not consulted
                if (hit[k])
                begin
                    cap_val[k] <= counter;
                end
                // Buffered: old primary value shifts down in the same edge
                if (buf_on[k] && hit[k])
                begin
                    cap_val[k+2] <= cap_val[k];
                end
                else if (!buf_on[k] && hit[k+2])
                begin
                    cap_val[k+2] <= counter;
                end
            end
        end
    end

    // Counter: clear on compare A beats increment, so a match at the top
    // value does not also raise overflow
    always_comb
    begin
        clear_now = compare_match_a & clear_on_match_a;
        overflow_ev = count_tick & ~clear_now & (counter == COUNTER_TOP);
        if (clear_now)
        begin
            next_counter = COUNTER_RST;
        end
        else if (count_tick)
        begin
            next_counter = counter + 16'h0001;
        end
        else
        begin
            next_counter = counter;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            counter <= COUNTER_RST;
        end
        else if (low_power_init)
        begin
            counter <= COUNTER_RST;
        end
        else
        begin
            counter <= next_counter;
        end
    end

    // Flag events; in buffered mode spare inputs still raise C and D
    assign set_ev = {hit[CH_A], hit[CH_B], hit[CH_C], hit[CH_D],
                     compare_match_a, compare_match_b, overflow_ev};

    // A zero write clears only a flag that was read as one; ones are ignored
    always_comb
    begin
        for (int i = 1; i < 8; i++)
        begin
            clr_ev[i] = wr_done && (a8 == OFF_FLAGS_CONTROL) &&
                        !pwdata[i] && flag_seen[i];
        end
    end

    // Status flags; a set in the same cycle as a clear wins
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            flags <= FLAGS_CONTROL_RST[7:1];
            flag_seen <= '0;
        end
        else if (low_power_init)
        begin
            flags <= FLAGS_CONTROL_RST[7:1];
            flag_seen <= '0;
        end
        else
        begin
            flags <= (flags & ~clr_ev) | set_ev;
            if (rd_done && a8 == OFF_FLAGS_CONTROL)
            begin
                flag_seen <= (flag_seen | prdata[7:1]) & ~clr_ev & ~set_ev;
            end
            else
            begin
                flag_seen <= flag_seen & ~clr_ev & ~set_ev;
            end
        end
    end

    // Plain read-write control bits
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_enable <= IRQ_ENABLE_RST[7:1];
            clear_on_match_a <= FLAGS_CONTROL_RST[BIT_CLEAR_ON_MATCH];
            setup <= SETUP_RST;
        end
        else if (low_power_init)
        begin
            irq_enable <= IRQ_ENABLE_RST[7:1];
            clear_on_match_a <= FLAGS_CONTROL_RST[BIT_CLEAR_ON_MATCH];
            setup <= SETUP_RST;
        end
        else if (wr_done)
        begin
            case (a8)
                // Bit 0 is never stored, so writes to it vanish
                OFF_IRQ_ENABLE: irq_enable <= pwdata[7:1];
                OFF_FLAGS_CONTROL:
                    clear_on_match_a <= pwdata[BIT_CLEAR_ON_MATCH];
                OFF_SETUP: setup <= tic_setup_t'(pwdata[7:0]);
                default: ;
            endcase
        end
    end

    // Read mux, evaluated in the setup cycle
    assign rd_ch = 2'((a8 - OFF_CAPTURE_BASE) >> CAPTURE_STRIDE_LOG2);
    assign rd_upper = ~a8[CAPTURE_LOW_BIT];

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_err = !addr_mapped(paddr);
        case (a8)
            OFF_IRQ_ENABLE: next_rdata[7:0] = {irq_enable, 1'b1};
            OFF_FLAGS_CONTROL: next_rdata[7:0] = {flags, clear_on_match_a};
            OFF_SETUP: next_rdata[7:0] = setup;
            OFF_COUNTER: next_rdata[15:0] = counter;
            default:
            begin
                if (!next_err)
                begin
                    // Lower view returns the latch, never the live register
                    next_rdata[7:0] = rd_upper ? cap_val[rd_ch][15:8]
                                               : hold_low;
                end
            end
        endcase
    end

    // Read data and error are snapshotted in the setup cycle so the access
    // phase shows stable values even if a capture lands meanwhile
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prdata <= 32'h0000_0000;
            err_q <= 1'b0;
        end
        else if (setup_phase)
        begin
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
            err_q <= next_err;
        end
    end

    // Holding latch: an upper-byte read catches the lower byte of the
    // same capture; it is taken with the upper byte, so both match
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hold_low <= HOLD_RST;
        end
        else if (low_power_init)
        begin
            hold_low <= HOLD_RST;
        end
        else if (setup_phase && !pwrite && !next_err && rd_upper &&
                 a8 >= OFF_CAPTURE_BASE)
        begin
            hold_low <= cap_val[rd_ch][7:0];
        end
    end

    // Requests are level, held for as long as flag and enable both stand
    assign irq = tic_irq_t'(flags & irq_enable);

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_buf_edge_a;
        buf_on[CH_A] && hit[CH_A] && !low_power_init;
    endsequence

    sequence s_buf_edge_b;
        buf_on[CH_B] && hit[CH_B] && !low_power_init;
    endsequence

    a_capture_loads_count: assert property (
        hit[CH_A] && !low_power_init |=>
            cap_val[CH_A] == $past(counter) && flags[BIT_CAPTURE_A])
        else $error("capture A did not load counter and flag");

    a_irq_follows_flag: assert property (
        $rose(flags[BIT_CAPTURE_D]) && irq_enable[BIT_CAPTURE_D]
            |-> irq.capture_irq_d)
        else $error("capture D request missing");

    a_buffer_shift_a: assert property (
        s_buf_edge_a |=> cap_val[CH_C] == $past(cap_val[CH_A]))
        else $error("buffered A did not shift into C");

    a_buffer_shift_b: assert property (
        s_buf_edge_b |=> cap_val[CH_D] == $past(cap_val[CH_B]))
        else $error("buffered B did not shift into D");

    a_spare_c_flag: assert property (
        buf_on[CH_A] && !hit[CH_A] && hit[CH_C] && !low_power_init |=>
            $stable(cap_val[CH_C]) && flags[BIT_CAPTURE_D + 1])
        else $error("spare C loaded or did not flag");

    a_undef_pair_idle: assert property (
        buf_on[CH_A] && sel[CH_A] && !sel[CH_C] |-> !hit[CH_A])
        else $error("undefined edge pair captured");

    a_reserved_reads_one: assert property (
        setup_phase && !pwrite && a8 == OFF_IRQ_ENABLE |=> prdata[0])
        else $error("reserved enable bit read as zero");

    a_flag_no_sw_set: assert property (
        !set_ev[BIT_OVERFLOW] |=> !$rose(flags[BIT_OVERFLOW]))
        else $error("overflow flag rose without an event");

    a_counter_clears: assert property (
        compare_match_a && clear_on_match_a && !low_power_init
            |=> counter == COUNTER_RST)
        else $error("counter not cleared on compare A");

    a_low_power_init: assert property (
        low_power_init |=> {irq_enable, 1'b1} == IRQ_ENABLE_RST &&
            {flags, clear_on_match_a} == FLAGS_CONTROL_RST &&
            cap_val[CH_B] == CAPTURE_RST)
        else $error("low-power entry did not initialise registers");

    a_hold_latch: assert property (
        setup_phase && !pwrite && a8 == OFF_CAPTURE_BASE && !low_power_init
            |=> hold_low == $past(cap_val[CH_A][7:0]))
        else $error("holding latch missed lower byte");

endmodule // tic_capture

// ### verif/tic_pulse_src.sv
// Behavioural pulse sources standing on the four capture pins.
// Assumes the bench asks for a level per pin; all timing on clk.
`timescale 1ns/1ps

module tic_pulse_src
#(
    parameter int MIN_HOLD = 3
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Requests from the bench
    input wire logic [3:0] want,
    input wire logic slow,
    // Pins and status
    output logic [3:0] capture_in,
    output logic settled
);
    // Cycles each pin has held its present level
    int held [4];
    // Cycles a request has waited, used by a slow source
    int lag;

    // A pin moves only once its old level has stood MIN_HOLD clocks,
    // which covers the longer both-edge minimum as well
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            capture_in <= 4'h0;
            lag <= 0;
            foreach (held[i]) held[i] <= MIN_HOLD;
        end
        else
        begin
            lag <= (want != capture_in) ? lag + 1 : 0;
            for (int i = 0; i < 4; i++)
            begin
                if (want[i] != capture_in[i] && held[i] >= MIN_HOLD
                    && (!slow || lag >= 4))
                begin
                    capture_in[i] <= want[i];
                    held[i] <= 0;
                end
                else if (held[i] < MIN_HOLD)
                    held[i] <= held[i] + 1;
            end
        end
    end

    // Settled once every pin matches and has held long enough
    always_comb
    begin
        settled = (want == capture_in);
        for (int i = 0; i < 4; i++)
            if (held[i] < MIN_HOLD) settled = 1'b0;
    end
endmodule // tic_pulse_src

// ### verif/testbench.sv
// Self-checking bench for the timer input-capture section.
// Assumes a zero-wait APB slave and pin sources from tic_pulse_src.
`timescale 1ns/1ps

module testbench;
    import tic_pkg::*;
    // Expected outcome of one APB transfer
    typedef struct packed {
        logic err;
        logic chk;
        logic [7:0] data;
    } tic_note_t;

    // Design and partner signals
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, settled, slow = 1'b0;
    logic [3:0] want = 4'h0, capture_in;
    logic count_tick = 1'b0, compare_match_a = 1'b0;
    logic compare_match_b = 1'b0, low_power_init = 1'b0;
    logic [15:0] free_running_counter;
    logic [1:0] clock_select;
    tic_irq_t irq;
    // Bench state
    int err_count = 0, check_count = 0;
    tic_note_t notes[$];
    tic_note_t note;
    logic [31:0] seed = 32'h59;
    logic [15:0] cnt = 16'h0000;
    logic [15:0] cap [4] = '{default: 16'h0000};
    logic [7:0] fl = 8'h00;

    always #5 clk = ~clk;

    tic_capture DUT (.clk(clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capture_in(capture_in),
        .count_tick(count_tick), .compare_match_a(compare_match_a),
        .compare_match_b(compare_match_b),
        .low_power_init(low_power_init),
        .free_running_counter(free_running_counter),
        .clock_select(clock_select), .irq(irq));

    tic_pulse_src src (.clk(clk), .rst_b(rst_b), .want(want),
        .slow(slow), .capture_in(capture_in), .settled(settled));

    // Fixed-seed xorshift source
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic cmp(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task end_sim();
        if (err_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50) err_count++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        notes.push_back('{1'b0, 1'b0, 8'h00});
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        notes.push_back('{1'b0, 1'b1, e});
        apb(1'b0, a, 32'h0);
    endtask

    // Upper view first, so the lower view comes from the same value
    task automatic rdcap(input int ch, input logic [15:0] v);
        rd(OFF_CAPTURE_BASE + 8'(8 * ch), v[15:8]);
        rd(OFF_CAPTURE_BASE + 8'(8 * ch + 4), v[7:0]);
    endtask

    // Count pulses, mirrored in the bench's own counter
    task automatic tick(input int n);
        repeat (n)
        begin
            count_tick <= 1'b1;
            @(posedge clk);
        end
        count_tick <= 1'b0;
        cnt += 16'(n);
        @(posedge clk);
    endtask

    // Move one pin; wait for the source, then the synchroniser delay
    task automatic pin(input int ch, input logic lvl);
        int n = 0;
        want[ch] <= lvl;
        slow <= 1'(rnd() & 1);
        @(negedge clk);
        while (!settled && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 40) err_count++;
        repeat (6) @(posedge clk);
    endtask

    task automatic pulse_a();
        compare_match_a <= 1'b1;
        @(posedge clk);
        compare_match_a <= 1'b0;
        @(posedge clk);
    endtask

    // Compare outputs away from the launching edge
    task automatic port_chk(input logic [7:0] en);
        @(negedge clk);
        cmp("irq", 16'((fl & en) >> 1), {9'h0, irq});
        cmp("counter", cnt, free_running_counter);
        @(posedge clk);
    endtask

    // Completed transfers are matched against the oldest note
    always @(posedge clk)
    begin
        if (psel && penable && pready && notes.size() > 0)
        begin
            note = notes.pop_front();
            cmp("pslverr", {15'h0, note.err}, {15'h0, pslverr});
            if (note.chk) cmp("prdata", {8'h0, note.data}, {8'h0, prdata[7:0]});
        end
    end

    initial
    begin
        // Overflow sweep needs a full counter wrap, about 66k cycles
        #900000;
        err_count++;
        end_sim();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(OFF_IRQ_ENABLE, 8'h01);
        rd(OFF_FLAGS_CONTROL, 8'h00);
        for (int ch = 0; ch < 4; ch++) rdcap(ch, 16'h0000);
        wr(OFF_IRQ_ENABLE, 8'hFE);
        rd(OFF_IRQ_ENABLE, 8'hFF);
        notes.push_back('{1'b1, 1'b0, 8'h00});
        apb(1'b0, 8'h30, 32'h0);
        // Each channel, each edge: the unselected edge must not capture
        for (int ch = 0; ch < 4; ch++)
            for (int s = 0; s < 2; s++)
            begin
                wr(OFF_SETUP, 8'(s << (7 - ch)));
                pin(ch, !s);
                tick(1 + rnd() % 20);
                pin(ch, s[0]);
                cap[ch] = cnt;
                tick(3);
                // Opposite edge after the counter moved must not reload
                pin(ch, !s);
                rdcap(ch, cap[ch]);
            end
        fl = 8'hF0;
        port_chk(8'hFE);
        wr(OFF_FLAGS_CONTROL, 8'hFF);
        rd(OFF_FLAGS_CONTROL, 8'hF1);
        wr(OFF_FLAGS_CONTROL, 8'h01);
        rd(OFF_FLAGS_CONTROL, 8'h01);
        compare_match_b <= 1'b1;
        @(posedge clk);
        compare_match_b <= 1'b0;
        pulse_a();
        cnt = 16'h0000;
        fl = 8'h0C;
        // Zero write before any read of the new flags must not clear them
        wr(OFF_FLAGS_CONTROL, 8'h01);
        rd(OFF_FLAGS_CONTROL, 8'h0D);
        port_chk(8'hFE);
        wr(OFF_FLAGS_CONTROL, 8'h00);
        rd(OFF_FLAGS_CONTROL, 8'h00);
        fl = 8'h00;
        tick(5);
        pulse_a();
        fl = 8'h08;
        port_chk(8'hFE);
        // Buffered pairs A/C and B/D with both edges selected
        for (int p = 0; p < 2; p++)
        begin
            wr(OFF_SETUP, (8'h80 >> (p + 2)) | (8'h08 >> p));
            for (int k = 0; k < 2; k++)
            begin
                tick(1 + rnd() % 9);
                pin(p, !k[0]);
                cap[p + 2] = cap[p];
                cap[p] = cnt;
            end
            rdcap(p, cap[p]);
            rdcap(p + 2, cap[p + 2]);
            tick(2);
            pin(p + 2, 1'b0);
            pin(p + 2, 1'b1);
            fl |= (8'h80 >> p) | (8'h20 >> p);
            rdcap(p + 2, cap[p + 2]);
            rd(OFF_FLAGS_CONTROL, fl);
            // Undefined select pair captures nothing
            wr(OFF_SETUP, (8'h80 >> p) | (8'h08 >> p) | 8'h02);
            cmp("clock_select", 16'h0002, {14'h0, clock_select});
            tick(2);
            pin(p, 1'b0);
            pin(p, 1'b1);
            rdcap(p, cap[p]);
        end
        // Run the counter through its top value to raise overflow
        tick(65536 - int'(cnt));
        fl |= 8'h02;
        rd(OFF_FLAGS_CONTROL, fl);
        wr(OFF_IRQ_ENABLE, 8'hA2);
        port_chk(8'hA2);
        low_power_init <= 1'b1;
        @(posedge clk);
        low_power_init <= 1'b0;
        @(posedge clk);
        cnt = 16'h0000;
        fl = 8'h00;
        rd(OFF_IRQ_ENABLE, 8'h01);
        rd(OFF_FLAGS_CONTROL, 8'h00);
        rdcap(2, 16'h0000);
        port_chk(8'h01);
        end_sim();
    end
endmodule // testbench
